// [design/mb_func_handler.v]
/*
 * Modbus slave request interpreter: takes a received request as a byte
 * stream, builds the reply byte stream, queues accepted writes for the
 * field loop and filters duplicates. Assumes framing/CRC handled outside,
 * and that the request ends with i_req_end after its last byte.
 */
`timescale 1ns/1ps
`include "mb_func_map.vh"

// Behaviour
// - diagnostics accepts only sub-functions 00, 02
// - sub-function 00 echoes request data exactly
// - sub-function 02 returns left/right unit status
// - status byte codes zero to four
// - function 15 writes whole registers like 16
// - at most 123 registers per write
// - accepted writes queued toward field loop
// - repeat of last forwarded address and value inside window discarded
// - outputs pulsed; later off write forwarded
// - slave ID reply: count, ID, run, versions
// - read codes 01 and 04 only honoured
// - basic objects vendor, product, revision only
// - identification reply header then objects
// - exception 01 bad function or length
// - exception 02 bad address or count
// - exception 03 illegal data value
// - exception 06 when queue lacks room
// - exception 0A unavailable or TCP unit mismatch
// - database eight parameters per block, 32 blocks
// - station address eight times block plus parameter
// - unit address 256+480B+60P+N-1
module mb_func_handler #(
  parameter [7:0] SLAVE_ID = 8'h5A, // value arbitrary
  parameter [15:0] HW_VERSION = 16'h0100,
  parameter [15:0] SW_VERSION = 16'h0100,
  parameter FILTER_CYCLES = `FILTER_CYCLES
)(
  input wire i_mclk,
  input wire i_rstn,
  input wire i_req_valid,
  input wire [7:0] i_req_byte,
  input wire i_req_end,
  input wire i_is_tcp,
  input wire [7:0] i_unit_id,
  input wire [7:0] i_tcp_addr,
  input wire i_available,
  input wire [7:0] i_left_status,
  input wire [7:0] i_right_status,
  input wire [15:0] i_db_limit,
  input wire i_rsp_ready,
  output reg o_rsp_valid,
  output reg [7:0] o_rsp_byte,
  output reg o_rsp_last,
  output wire o_busy,
  input wire i_loop_ready,
  output reg o_loop_valid,
  output reg [15:0] o_loop_addr,
  output reg [15:0] o_loop_value,
  output reg o_loop_pulse
);
  // ****************************************************************
  // identification strings (contents arbitrary)
  // ****************************************************************
  function [7:0] id_char;
    input [1:0] obj;
    input [4:0] idx;
    reg [95:0] s;
    begin
      case (obj)
        2'd0: s = {32'h00000000, "VENDOR-X"} >> (8 * (7 - idx));
        2'd1: s = "LOOP-GATEWAY" >> (8 * (11 - idx));
        default: s = {56'h00000000000000, "V1.00"} >> (8 * (4 - idx));
      endcase
      id_char = s[7:0];
    end
  endfunction
  function [4:0] id_len;
    input [1:0] obj;
    begin
      case (obj)
        2'd0: id_len = 5'd8;
        2'd1: id_len = 5'd12;
        default: id_len = 5'd5;
      endcase
    end
  endfunction
  function addr_ok;
    input [15:0] a;
    input [15:0] lim;
    begin
      addr_ok = (a < (`PARAMS_PER_BLOCK * `BLOCKS)) || ((a >= `FIELD_UNIT_BASE) && (a < lim));
    end
  endfunction

  // ****************************************************************
  // request capture
  // ****************************************************************
  localparam S_RX = 3'd0;
  localparam S_EVAL = 3'd1;
  localparam S_QUEUE = 3'd2;
  localparam S_TX = 3'd3;

  reg [2:0] state;
  reg [7:0] rx_len;
  reg [7:0] tx_idx;
  reg [7:0] tx_len;
  reg [7:0] func;
  reg [7:0] exc;
  reg [7:0] wr_left;
  reg [7:0] wr_pos;
  reg [15:0] wr_addr;
  reg [1:0] obj;
  reg [4:0] chr;
  reg [1:0] obj_phase;
  reg [7:0] q_head;
  reg [7:0] q_tail;
  reg [8:0] q_count;
  reg [7:0] req [0:7];
  wire [7:0] ram_rd;
  reg [7:0] ram_raddr;
  wire ram_we;
  wire [15:0] start;
  wire [15:0] qty;
  wire [15:0] sub;
  wire filt_pass;
  wire [15:0] w_val;
  reg [15:0] q_mem_addr [0:`QUEUE_WORDS-1];
  reg [15:0] q_mem_val [0:`QUEUE_WORDS-1];
  reg [7:0] rd_hi;

  assign start = {req[1], req[2]};
  assign qty = {req[3], req[4]};
  assign sub = {req[1], req[2]};
  assign ram_we = (state == S_RX) && i_req_valid;
  assign o_busy = (state != S_RX);

  mb_byte_ram #(
    .WIDTH(8),
    .AW(8)
  ) u_req_ram (
    .i_mclk(i_mclk),
    .i_we(ram_we),
    .i_waddr(rx_len),
    .i_wdata(i_req_byte),
    .i_raddr(ram_raddr),
    .o_rdata(ram_rd)
  );

  always @*
  begin
    case (state)
      S_EVAL: ram_raddr = 8'd6; // first write data byte, read one cycle ahead
      S_QUEUE: ram_raddr = wr_pos;
      default: ram_raddr = tx_idx + {7'h00, i_rsp_ready && o_rsp_valid};
    endcase
  end

  always @(posedge i_mclk)
  begin
    if (ram_we && rx_len < 8'd8)
    begin
      req[rx_len[2:0]] <= i_req_byte;
    end
  end

  // ****************************************************************
  // main sequencer
  // ****************************************************************
  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= S_RX;
      rx_len <= 8'h00;
      tx_idx <= 8'h00;
      tx_len <= 8'h00;
      func <= 8'h00;
      exc <= 8'h00;
      wr_left <= 8'h00;
      wr_pos <= 8'h00;
      wr_addr <= 16'h0000;
      obj <= 2'd0;
      chr <= 5'd0;
      obj_phase <= 2'd0;
      q_tail <= 8'h00;
      rd_hi <= 8'h00;
    end
    else
    begin
      case (state)
        S_RX:
        begin
          tx_idx <= 8'h00;
          if (i_req_valid && rx_len != 8'hFF)
          begin
            rx_len <= rx_len + 8'h01;
          end
          if (i_req_end)
          begin
            state <= S_EVAL;
          end
        end
        S_EVAL:
        begin
          func <= req[0];
          exc <= 8'h00;
          tx_idx <= 8'h00;
          state <= S_TX;
          if (!i_available || (i_is_tcp && i_unit_id != i_tcp_addr))
          begin
            exc <= `EXC_GATEWAY;
          end
          else
          begin
            case (req[0])
              `FC_DIAG:
              begin
                if (rx_len < 8'd5)
                begin
                  exc <= `EXC_FUNC;
                end
                else if (sub == `SUB_ECHO)
                begin
                  tx_len <= rx_len;
                end
                else if (sub == `SUB_STATUS)
                begin
                  tx_len <= 8'd5;
                end
                else
                begin
                  exc <= `EXC_FUNC;
                end
              end
              `FC_WR_COILS, `FC_WR_REGS:
              begin
                // coils and registers share one whole-word location
                if (rx_len < 8'd6 || rx_len != 8'd6 + req[5])
                begin
                  exc <= `EXC_FUNC;
                end
                else if (qty == 16'h0000 || qty > `MAX_WR_REGS)
                begin
                  exc <= `EXC_ADDR;
                end
                else if (!addr_ok(start, i_db_limit) || !addr_ok(start + qty - 16'h0001, i_db_limit))
                begin
                  exc <= `EXC_ADDR;
                end
                else if (req[0] == `FC_WR_REGS && req[5] != {qty[6:0], 1'b0})
                begin
                  exc <= `EXC_VALUE;
                end
                else if ({1'b0, qty} > (16'd`QUEUE_WORDS - {7'h00, q_count}))
                begin
                  exc <= `EXC_BUSY;
                end
                else
                begin
                  wr_left <= qty[7:0];
                  wr_pos <= 8'd7;
                  wr_addr <= start;
                  tx_len <= 8'd5;
                  state <= S_QUEUE;
                end
              end
              `FC_SLAVE_ID:
              begin
                tx_len <= 8'd9;
              end
              `FC_DEV_ID:
              begin
                if (rx_len != 8'd4 || req[1] != `MEI_TYPE)
                begin
                  exc <= `EXC_FUNC;
                end
                else if (req[2] != `RD_BASIC && req[2] != `RD_ONE)
                begin
                  exc <= `EXC_VALUE;
                end
                else if (req[2] == `RD_ONE && req[3] > `OBJ_LAST)
                begin
                  exc <= `EXC_ADDR;
                end
                else
                begin
                  obj <= (req[2] == `RD_ONE) ? req[3][1:0] : 2'd0;
                  obj_phase <= 2'd0;
                  chr <= 5'd0;
                  tx_len <= 8'd7;
                end
              end
              default:
              begin
                exc <= `EXC_FUNC;
              end
            endcase
          end
        end
        S_QUEUE:
        begin
          // two bytes per word; FC15 data is treated as words as well
          if (wr_left == 8'h00)
          begin
            state <= S_TX;
          end
          else if (wr_pos[0])
          begin
            rd_hi <= ram_rd;
            wr_pos <= wr_pos + 8'h01;
          end
          else
          begin
            if (filt_pass)
            begin
              q_tail <= q_tail + 8'h01;
            end
            wr_addr <= wr_addr + 16'h0001;
            wr_left <= wr_left - 8'h01;
            wr_pos <= wr_pos + 8'h01;
          end
        end
        S_TX:
        begin
          if (i_rsp_ready && o_rsp_valid)
          begin
            tx_idx <= tx_idx + 8'h01;
            if (func == `FC_DEV_ID && exc == 8'h00 && tx_idx >= 8'd7)
            begin
              if (obj_phase == 2'd2)
              begin
                if (chr == id_len(obj) - 5'd1)
                begin
                  obj_phase <= 2'd0;
                  chr <= 5'd0;
                  obj <= obj + 2'd1;
                end
                else
                begin
                  chr <= chr + 5'd1;
                end
              end
              else
              begin
                obj_phase <= obj_phase + 2'd1;
              end
            end
            if (o_rsp_last)
            begin
              rx_len <= 8'h00;
              state <= S_RX;
            end
          end
        end
        default:
        begin
          state <= S_RX;
        end
      endcase
    end
  end

  // ****************************************************************
  // reply byte selection
  // ****************************************************************
  wire dev_all;
  wire [7:0] obj_end;
  assign dev_all = (req[2] == `RD_BASIC);
  assign obj_end = dev_all ? 8'd2 : {6'd0, obj};

  always @*
  begin
    o_rsp_valid = (state == S_TX);
    o_rsp_byte = 8'h00;
    o_rsp_last = 1'b0;
    if (exc != 8'h00)
    begin
      o_rsp_byte = (tx_idx == 8'h00) ? (func | `FC_ERR_BIT) : exc;
      o_rsp_last = (tx_idx == 8'h01);
    end
    else
    begin
      case (func)
        `FC_DIAG:
        begin
          if (sub == `SUB_STATUS)
          begin
            case (tx_idx)
              8'd3: o_rsp_byte = i_left_status;
              8'd4: o_rsp_byte = i_right_status;
              default: o_rsp_byte = req[tx_idx[2:0]];
            endcase
            o_rsp_last = (tx_idx == 8'd4);
          end
          else
          begin
            o_rsp_byte = (tx_idx < 8'd8) ? req[tx_idx[2:0]] : ram_rd;
            o_rsp_last = (tx_idx == tx_len - 8'h01);
          end
        end
        `FC_WR_COILS, `FC_WR_REGS:
        begin
          o_rsp_byte = req[tx_idx[2:0]];
          o_rsp_last = (tx_idx == 8'd4);
        end
        `FC_SLAVE_ID:
        begin
          case (tx_idx)
            8'd0: o_rsp_byte = func;
            8'd1: o_rsp_byte = `SID_BYTE_COUNT;
            8'd2: o_rsp_byte = SLAVE_ID;
            8'd3: o_rsp_byte = `SID_RUN;
            8'd4: o_rsp_byte = HW_VERSION[15:8];
            8'd5: o_rsp_byte = HW_VERSION[7:0];
            8'd6: o_rsp_byte = SW_VERSION[15:8];
            default: o_rsp_byte = SW_VERSION[7:0];
          endcase
          o_rsp_last = (tx_idx == 8'd7);
        end
        default:
        begin
          case (tx_idx)
            8'd0: o_rsp_byte = `FC_DEV_ID;
            8'd1: o_rsp_byte = `MEI_TYPE;
            8'd2: o_rsp_byte = req[2];
            8'd3: o_rsp_byte = `CONFORMITY;
            8'd4: o_rsp_byte = 8'h00;
            8'd5: o_rsp_byte = 8'h00;
            8'd6: o_rsp_byte = dev_all ? `OBJ_COUNT : 8'h01;
            default:
            begin
              case (obj_phase)
                2'd0: o_rsp_byte = {6'd0, obj};
                2'd1: o_rsp_byte = {3'd0, id_len(obj)};
                default: o_rsp_byte = id_char(obj, chr);
              endcase
              o_rsp_last = (obj_phase == 2'd2) && (chr == id_len(obj) - 5'd1) && ({6'd0, obj} == obj_end);
            end
          endcase
        end
      endcase
    end
  end

  // ****************************************************************
  // outgoing write queue toward the loop network
  // ****************************************************************
  assign w_val = {rd_hi, ram_rd};

  mb_cmd_filter #(
    .WINDOW_CYCLES(FILTER_CYCLES)
  ) u_filter (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_check((state == S_QUEUE) && (wr_left != 8'h00) && !wr_pos[0]),
    .i_addr(wr_addr),
    .i_value(w_val),
    .o_pass(filt_pass)
  );

  always @(posedge i_mclk)
  begin
    if (state == S_QUEUE && wr_left != 8'h00 && !wr_pos[0] && filt_pass)
    begin
      q_mem_addr[q_tail] <= wr_addr;
      q_mem_val[q_tail] <= w_val;
    end
  end

  wire q_push;
  wire q_pop;
  assign q_push = (state == S_QUEUE) && (wr_left != 8'h00) && !wr_pos[0] && filt_pass;
  assign q_pop = o_loop_valid && i_loop_ready;

  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      q_head <= 8'h00;
      q_count <= 9'h000;
      o_loop_valid <= 1'b0;
      o_loop_addr <= 16'h0000;
      o_loop_value <= 16'h0000;
      o_loop_pulse <= 1'b0;
    end
    else
    begin
      q_count <= q_count + {8'h00, q_push} - {8'h00, q_pop};
      if (q_pop || !o_loop_valid)
      begin
        if (q_count != 9'h000 && q_head != q_tail)
        begin
          o_loop_valid <= 1'b1;
          o_loop_addr <= q_mem_addr[q_head];
          o_loop_value <= q_mem_val[q_head];
          // nonzero drives a pulse; zero is forwarded but inert
          o_loop_pulse <= (q_mem_val[q_head] != 16'h0000);
          q_head <= q_head + 8'h01;
        end
        else
        begin
          o_loop_valid <= 1'b0;
        end
      end
    end
  end
endmodule // mb_func_handler

// [design/mb_func_map.vh]
/*
 * Constants for the Modbus request interpreter: function codes, exception
 * codes, diagnostic sub-functions, identification fields and limits.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MB_FUNC_MAP_VH
`define MB_FUNC_MAP_VH

`define FC_DIAG 8'h08
`define FC_WR_COILS 8'h0F
`define FC_WR_REGS 8'h10
`define FC_SLAVE_ID 8'h11
`define FC_DEV_ID 8'h2B
`define FC_ERR_BIT 8'h80

`define SUB_ECHO 16'h0000
`define SUB_STATUS 16'h0002

`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define EXC_BUSY 8'h06
`define EXC_GATEWAY 8'h0A

`define MEI_TYPE 8'h0E
`define RD_BASIC 8'h01
`define RD_REGULAR 8'h02
`define RD_EXTENDED 8'h03
`define RD_ONE 8'h04
`define CONFORMITY 8'h01
`define OBJ_COUNT 8'h03
`define OBJ_LAST 8'h02

`define SID_BYTE_COUNT 8'h06
`define SID_RUN 8'hFF

`define MAX_WR_REGS 16'h007B
`define REQ_BYTES 256
`define QUEUE_WORDS 256
`define QUEUE_AW 8

`define FIELD_UNIT_BASE 16'h0100
`define FIELD_UNIT_BLOCK_STEP 16'h01E0
`define FIELD_UNIT_PARAM_STEP 16'h003C
`define PARAMS_PER_BLOCK 16'h0008
`define BLOCKS 32
`define FILTER_US 100000
`define CLK_MHZ 20
`define FILTER_CYCLES (`FILTER_US * `CLK_MHZ)

`endif

// [design/mb_byte_ram.v]
/*
 * Small synchronous memory, one write port and one registered read port.
 * Assumes a single clock; contents are undefined until written.
 */
`timescale 1ns/1ps
module mb_byte_ram #(
  parameter WIDTH = 8,
  parameter AW = 8
)(
  input wire i_mclk,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [WIDTH-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [WIDTH-1:0] o_rdata
);
  reg [WIDTH-1:0] mem [0:(1<<AW)-1];
  always @(posedge i_mclk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // mb_byte_ram

// [design/mb_cmd_filter.v]
/*
 * Duplicate-command filter: remembers the last forwarded unit address and
 * value, and drops an identical command seen within the filter window.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`include "mb_func_map.vh"
module mb_cmd_filter #(
  parameter WINDOW_CYCLES = `FILTER_CYCLES
)(
  input wire i_mclk,
  input wire i_rstn,
  input wire i_check,
  input wire [15:0] i_addr,
  input wire [15:0] i_value,
  output wire o_pass
);
  reg [15:0] last_addr;
  reg [15:0] last_value;
  reg [31:0] age;
  reg seen;
  wire dup;

  assign dup = seen && (age < WINDOW_CYCLES) && (last_addr == i_addr) && (last_value == i_value);
  assign o_pass = !dup;

  always @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      last_addr <= 16'h0000;
      last_value <= 16'h0000;
      age <= 32'h00000000;
      seen <= 1'b0;
    end
    else if (i_check && !dup)
    begin
      last_addr <= i_addr;
      last_value <= i_value;
      age <= 32'h00000000;
      seen <= 1'b1;
    end
    else if (age != 32'hFFFFFFFF)
    begin
      age <= age + 32'h00000001;
    end
  end
endmodule // mb_cmd_filter

// [testbench/mb_func_monitor.sv]
/* Assertion checker for the Modbus request interpreter.
   Assumes bind onto mb_func_handler, one clock, active-low async reset. */
`timescale 1ns/1ps
`include "mb_func_map.vh"
module mb_func_monitor #(
  parameter FILTER_CYCLES = 50
)(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  input wire logic [7:0] i_req_byte,
  input wire logic i_req_end,
  input wire logic i_is_tcp,
  input wire logic [7:0] i_unit_id,
  input wire logic [7:0] i_tcp_addr,
  input wire logic i_available,
  input wire logic [7:0] i_left_status,
  input wire logic [7:0] i_right_status,
  input wire logic [15:0] i_db_limit,
  input wire logic i_rsp_ready,
  input wire logic o_rsp_valid,
  input wire logic [7:0] o_rsp_byte,
  input wire logic o_rsp_last,
  input wire logic o_busy,
  input wire logic i_loop_ready,
  input wire logic o_loop_valid,
  input wire logic [15:0] o_loop_addr,
  input wire logic [15:0] o_loop_value,
  input wire logic o_loop_pulse
);
  // ***************************
  // function code of the request
  // ***************************
  reg [7:0] fc;
  reg fresh;
  always @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      fc <= 8'h00;
      fresh <= 1'b1;
    end
    else if (i_req_valid && !o_busy)
    begin
      if (fresh)
        fc <= i_req_byte;
      fresh <= 1'b0;
    end
    else if (i_req_end)
      fresh <= 1'b1;

  // ***************************
  // properties
  // ***************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  reply_head_a: assert property ($rose(o_rsp_valid) |-> o_rsp_byte == fc || o_rsp_byte == (fc | `FC_ERR_BIT))
    else $error("reply does not start with the function code");
  reply_soon_a: assert property (i_req_end && fc != `FC_WR_REGS && fc != `FC_WR_COILS |-> ##[1:3] o_rsp_valid)
    else $error("reply late");
  byte_stands_a: assert property (o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_byte) && $stable(o_rsp_last))
    else $error("reply byte changed before taken");
  last_drop_a: assert property (o_rsp_valid && i_rsp_ready && o_rsp_last |=> !o_rsp_valid)
    else $error("reply valid after last byte");
  busy_reply_a: assert property (o_rsp_valid |-> o_busy)
    else $error("reply while not busy");
  loop_hold_a: assert property (o_loop_valid && !i_loop_ready |=> o_loop_valid && $stable({o_loop_addr, o_loop_value}))
    else $error("loop word dropped or changed");
  pulse_flag_a: assert property (o_loop_valid |-> o_loop_pulse == (o_loop_value != 16'h0000))
    else $error("pulse flag wrong");
  sid_count_a: assert property ($rose(o_rsp_valid) && i_rsp_ready && o_rsp_byte == `FC_SLAVE_ID |=> o_rsp_byte == `SID_BYTE_COUNT)
    else $error("slave id byte count wrong");
  id_type_a: assert property ($rose(o_rsp_valid) && i_rsp_ready && o_rsp_byte == `FC_DEV_ID |=> o_rsp_byte == `MEI_TYPE)
    else $error("identification type not echoed");
  unavail_exc_a: assert property ($rose(o_rsp_valid) && !i_available |-> o_rsp_byte == (fc | `FC_ERR_BIT))
    else $error("no exception while unavailable");

  cover property ($rose(o_rsp_valid) && o_rsp_byte == `FC_DIAG);
  cover property ($rose(o_rsp_valid) && o_rsp_byte[7]);
  cover property (o_loop_valid && !i_loop_ready);
endmodule // mb_func_monitor

bind mb_func_handler mb_func_monitor #(.FILTER_CYCLES(FILTER_CYCLES)) i_mon (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req_valid(i_req_valid), .i_req_byte(i_req_byte),
  .i_req_end(i_req_end), .i_is_tcp(i_is_tcp), .i_unit_id(i_unit_id), .i_tcp_addr(i_tcp_addr),
  .i_available(i_available), .i_left_status(i_left_status), .i_right_status(i_right_status),
  .i_db_limit(i_db_limit), .i_rsp_ready(i_rsp_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte),
  .o_rsp_last(o_rsp_last), .o_busy(o_busy), .i_loop_ready(i_loop_ready), .o_loop_valid(o_loop_valid),
  .o_loop_addr(o_loop_addr), .o_loop_value(o_loop_value), .o_loop_pulse(o_loop_pulse));

// [testbench/loop_sink.sv]
/* Field loop model: takes queued words, logs them, stalls on request.
   Assumes the block's clock and active-low reset. */
`timescale 1ns/1ps
module loop_sink (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_value,
  input wire logic i_pulse,
  output logic o_ready
);
  logic [32:0] words[$];
  logic slow;
  // ready only every other cycle: a slow loop
  always @(posedge i_mclk or negedge i_rstn)
    if (!i_rstn)
    begin
      o_ready <= 1'b0;
      slow <= 1'b0;
    end
    else
    begin
      if (i_valid && o_ready)
        words.push_back({i_pulse, i_addr, i_value});
      slow <= ~slow;
      o_ready <= !i_stall && slow;
    end
endmodule // loop_sink

// [testbench/modbus_slave_function_handler_bench.sv]
/* Self-checking bench for the Modbus request interpreter.
   Assumes mb_func_handler, loop_sink and the bound checker. */
`timescale 1ns/1ps
module modbus_slave_function_handler_bench;
  typedef logic [7:0] bq[$];
  logic i_mclk = 0, i_rstn = 0, i_req_valid = 0, i_req_end = 0, i_is_tcp = 0, i_available = 1;
  logic i_rsp_ready = 0, i_stall = 0;
  logic [7:0] i_req_byte = 8'h00, i_unit_id = 8'h00, i_tcp_addr = 8'h00, i_left_status = 8'h00, i_right_status = 8'h00;
  logic [15:0] i_db_limit = 16'h0200;
  wire o_rsp_valid, o_rsp_last, o_busy, i_loop_ready, o_loop_valid, o_loop_pulse;
  wire [7:0] o_rsp_byte;
  wire [15:0] o_loop_addr, o_loop_value;
  int n_mismatch = 0, num_checks = 0;

  always #25 i_mclk = ~i_mclk;

  mb_func_handler #(.FILTER_CYCLES(50)) i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req_valid(i_req_valid),
    .i_req_byte(i_req_byte), .i_req_end(i_req_end), .i_is_tcp(i_is_tcp), .i_unit_id(i_unit_id),
    .i_tcp_addr(i_tcp_addr), .i_available(i_available), .i_left_status(i_left_status),
    .i_right_status(i_right_status), .i_db_limit(i_db_limit), .i_rsp_ready(i_rsp_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte), .o_rsp_last(o_rsp_last), .o_busy(o_busy),
    .i_loop_ready(i_loop_ready), .o_loop_valid(o_loop_valid), .o_loop_addr(o_loop_addr),
    .o_loop_value(o_loop_value), .o_loop_pulse(o_loop_pulse));
  loop_sink i_sink (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_stall(i_stall), .i_valid(o_loop_valid),
    .i_addr(o_loop_addr), .i_value(o_loop_value), .i_pulse(o_loop_pulse), .o_ready(i_loop_ready));

  // ***************************
  // shared tasks
  // ***************************
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // send a request, take the reply with a toggling ready, compare
  task automatic xfer(input bq rq, input bq ex, input bit whole);
    bq got;
    int n;
    foreach (rq[i])
    begin
      i_req_valid <= 1'b1;
      i_req_byte <= rq[i];
      @(posedge i_mclk);
    end
    i_req_valid <= 1'b0;
    i_req_end <= 1'b1;
    @(posedge i_mclk);
    i_req_end <= 1'b0;
    i_rsp_ready <= 1'b0;
    n = 0;
    while (n < 3000)
    begin
      @(posedge i_mclk);
      n++;
      if (o_rsp_valid === 1'b1 && i_rsp_ready === 1'b1)
      begin
        got.push_back(o_rsp_byte);
        if (o_rsp_last === 1'b1)
          break;
      end
      i_rsp_ready <= ~i_rsp_ready;
    end
    if (n == 3000)
    begin
      n_mismatch++;
      give_verdict;
    end
    if (whole)
      chk(got.size(), ex.size());
    foreach (ex[i])
      chk(got[i], ex[i]);
  endtask

  task automatic wait_words(input int k);
    int n;
    n = 0;
    while (i_sink.words.size() < k && n < 2000)
    begin
      @(posedge i_mclk);
      n++;
    end
    chk(i_sink.words.size(), k);
    if (n == 2000)
      give_verdict;
  endtask

  function automatic bq wr(input logic [15:0] a, input int q, input logic [7:0] bc, input int n);
    bq r;
    r = '{8'h10, a[15:8], a[7:0], 8'h00, 8'(q), bc};
    for (int i = 1; i <= n; i++)
    begin
      r.push_back(8'h00);
      r.push_back(8'(i % n));
    end
    return r;
  endfunction

  // ***************************
  // scenarios
  // ***************************
  task automatic t_diag;
    xfer('{8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, '{8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1);
    for (int s = 0; s < 5; s++)
    begin
      i_left_status <= 8'(s);
      i_right_status <= 8'(4 - s);
      xfer('{8'h08, 8'h00, 8'h02, 8'h00, 8'h00}, '{8'h08, 8'h00, 8'h02, 8'(s), 8'(4 - s)}, 1);
    end
    xfer('{8'h08, 8'h00, 8'h01, 8'h00, 8'h00}, '{8'h88, 8'h01}, 1);
    xfer('{8'h07}, '{8'h87, 8'h01}, 1);
  endtask

  task automatic t_ident;
    xfer('{8'h11}, '{8'h11, 8'h06, 8'h5A, 8'hFF, 8'h01, 8'h00, 8'h01, 8'h00}, 1);
    xfer('{8'h2B, 8'h0E, 8'h01, 8'h00}, '{8'h2B, 8'h0E, 8'h01, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00}, 0);
    xfer('{8'h2B, 8'h0E, 8'h02, 8'h00}, '{8'hAB, 8'h03}, 1);
    xfer('{8'h2B, 8'h0E, 8'h03, 8'h00}, '{8'hAB, 8'h03}, 1);
    xfer('{8'h2B, 8'h0E, 8'h04, 8'h01}, '{8'h2B, 8'h0E, 8'h04}, 0);
    xfer('{8'h2B, 8'h0E, 8'h04, 8'h03}, '{8'hAB, 8'h02}, 1);
  endtask

  task automatic t_write;
    xfer(wr(16'h0100, 2, 8'h04, 2), '{8'h10, 8'h01, 8'h00, 8'h00, 8'h02}, 1);
    wait_words(2);
    chk(i_sink.words[0], {1'b1, 16'h0100, 16'h0001});
    chk(i_sink.words[1], {1'b0, 16'h0101, 16'h0000});
    xfer('{8'h0F, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'hFF, 8'h00}, '{8'h0F, 8'h01, 8'h02, 8'h00, 8'h01}, 1);
    wait_words(3);
    chk(i_sink.words[2], {1'b1, 16'h0102, 16'hFF00});
    xfer('{8'h10, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'hFF, 8'h00}, '{8'h10, 8'h01, 8'h02, 8'h00, 8'h01}, 1);
    repeat (60) @(posedge i_mclk);
    chk(i_sink.words.size(), 3);
    xfer('{8'h10, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02, 8'hFF, 8'h00}, '{8'h10, 8'h01, 8'h02, 8'h00, 8'h01}, 1);
    wait_words(4);
    xfer(wr(16'h0100, 124, 8'hF8, 124), '{8'h90, 8'h02}, 1);
    xfer(wr(16'h0100, 0, 8'h00, 0), '{8'h90, 8'h02}, 1);
    xfer(wr(16'h0100, 1, 8'h04, 2), '{8'h90, 8'h03}, 1);
    xfer(wr(16'h01FF, 2, 8'h04, 2), '{8'h90, 8'h02}, 1);
    xfer(wr(16'h01FE, 2, 8'h04, 2), '{8'h10, 8'h01, 8'hFE, 8'h00, 8'h02}, 1);
    wait_words(6);
  endtask

  task automatic t_queue;
    i_stall <= 1'b1;
    xfer(wr(16'h0100, 123, 8'hF6, 123), '{8'h10, 8'h01, 8'h00, 8'h00, 8'h7B}, 1);
    xfer(wr(16'h0100, 123, 8'hF6, 123), '{8'h10, 8'h01, 8'h00, 8'h00, 8'h7B}, 1);
    xfer(wr(16'h0100, 123, 8'hF6, 123), '{8'h90, 8'h06}, 1);
    i_stall <= 1'b0;
    wait_words(252);
    chk(i_sink.words[251], {1'b0, 16'h017A, 16'h0000});
    xfer(wr(16'h00FF, 1, 8'h02, 1), '{8'h10, 8'h00, 8'hFF, 8'h00, 8'h01}, 1);
    wait_words(253);
  endtask

  task automatic t_avail;
    i_available <= 1'b0;
    xfer('{8'h08, 8'h00, 8'h00, 8'h55, 8'hAA}, '{8'h88, 8'h0A}, 1);
    i_available <= 1'b1;
    i_is_tcp <= 1'b1;
    i_unit_id <= 8'h11;
    i_tcp_addr <= 8'h22;
    xfer('{8'h08, 8'h00, 8'h00, 8'h55, 8'hAA}, '{8'h88, 8'h0A}, 1);
    i_unit_id <= 8'h22;
    xfer('{8'h08, 8'h00, 8'h00, 8'h55, 8'hAA}, '{8'h08, 8'h00, 8'h00, 8'h55, 8'hAA}, 1);
    i_is_tcp <= 1'b0;
  endtask

  initial
  begin
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1'b1;
    @(posedge i_mclk);
    t_diag;
    t_ident;
    t_write;
    t_queue;
    t_avail;
    give_verdict;
  end
endmodule // modbus_slave_function_handler_bench
